// File: src/csf_pkg.sv
package csf_pkg;

  // ----------------------------------------------------------------
  // apb register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int         APB_AW      = 8;
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_OPND   = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_FLAGS  = 8'h0C;
  localparam logic [7:0] ADDR_SP     = 8'h10;
  localparam logic [7:0] ADDR_PC     = 8'h14;
  localparam logic [7:0] ADDR_VEC    = 8'h18;
  localparam logic [7:0] ADDR_COND   = 8'h1C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CMD_OP2_LSB    = 8;
  localparam int OPND_SRC_LSB   = 8;
  localparam int RES_WB_BIT     = 8;
  localparam int RES_CAUSE_LSB  = 9;
  localparam int RES_BUSY_BIT   = 16;
  localparam int RES_IRQ_BIT    = 17;
  localparam int COND_CC_LSB    = 4;

  // ----------------------------------------------------------------
  // reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [15:0] SP_RST  = 16'h0000;
  localparam logic [15:0] PC_RST  = 16'h0000;
  localparam logic [15:0] VEC_RST = 16'h0000;
  localparam int          STK_AW  = 4;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SUB     = 8'h22;
  localparam logic [7:0] OP_SUBTRACT_EXTENDED    = 8'h28;
  localparam logic [7:0] OP_SBC     = 8'h32;
  localparam logic [7:0] OP_SBCX    = 8'h38;
  localparam logic [7:0] OP_OR      = 8'h42;
  localparam logic [7:0] OP_TCM     = 8'h62;
  localparam logic [7:0] OP_INVERTED_MASK_TEST_EXTENDED    = 8'h68;
  localparam logic [7:0] OP_TM      = 8'h72;
  localparam logic [7:0] OP_TMX     = 8'h78;
  localparam logic [7:0] OP_XOR     = 8'hB2;
  localparam logic [7:0] OP_RCF     = 8'hCF;
  localparam logic [7:0] OP_SCF     = 8'hDF;
  localparam logic [7:0] OP_SWAP    = 8'hF0;
  localparam logic [7:0] OP_TRAP    = 8'hF2;
  localparam logic [7:0] OP_INTERRUPT_RETURN_OP    = 8'hFE;
  localparam logic [7:0] OP_PREFIX  = 8'h1F;
  localparam logic [7:0] OP2_SRL_R  = 8'hC0;
  localparam logic [7:0] OP2_SRL_IR = 8'hC1;

  // ----------------------------------------------------------------
  // trap causes
  // ----------------------------------------------------------------
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_SW   = 2'h1;
  localparam logic [1:0] CAUSE_IRQ  = 2'h2;
  localparam logic [1:0] CAUSE_ILL  = 2'h3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
  } csf_cond_t;

  typedef struct packed {
    csf_cond_t  cond;
    logic [1:0] uf;
  } csf_flags_t;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_T_SPDEC2 = 4'b0001,
    ST_T_PCH    = 4'b0010,
    ST_T_PCL    = 4'b0011,
    ST_T_FLG    = 4'b0100,
    ST_T_VEC    = 4'b0101,
    ST_R_FLG    = 4'b0110,
    ST_R_PC     = 4'b0111
  } csf_state_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
  } csf_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } csf_apb_rsp_t;

endpackage

// File: src/csf_stack.sv
`timescale 1ns/1ps
module csf_stack import csf_pkg::*; #(
  parameter int AW = STK_AW
) (
  input  wire logic          clk_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [7:0]    wdata_in,
  input  wire logic [AW-1:0] raddr_a_in,
  input  wire logic [AW-1:0] raddr_b_in,
  output logic      [7:0]    rdata_a_out,
  output logic      [7:0]    rdata_b_out
);

  // ----------------------------------------------------------------
  // byte storage, contents undefined until written
  // ----------------------------------------------------------------
  logic [7:0] mem_q [2**AW];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  assign rdata_a_out = mem_q[raddr_a_in];
  assign rdata_b_out = mem_q[raddr_b_in];

endmodule

// File: src/csf_alu.sv
`timescale 1ns/1ps
module csf_alu import csf_pkg::*; (
  input  wire logic      [7:0] op_in,
  input  wire logic      [7:0] op2_in,
  input  wire logic      [7:0] dst_in,
  input  wire logic      [7:0] src_in,
  input  wire csf_cond_t       cond_in,
  output logic           [7:0] res_out,
  output logic                 wb_out,
  output csf_cond_t            cond_out,
  output logic                 legal_out
);

  logic [8:0] diff;
  logic [4:0] hdiff;
  logic       cin;
  logic [7:0] a;

  always_comb begin
    res_out   = dst_in;
    wb_out    = 1'b0;
    cond_out  = cond_in;              // unmarked flags stay
    legal_out = 1'b1;
    cin       = ((op_in == OP_SBC) || (op_in == OP_SBCX)) ? cond_in.c : 1'b0;
    diff      = {1'b0, dst_in} - {1'b0, src_in} - {8'h00, cin};
    hdiff     = {1'b0, dst_in[3:0]} - {1'b0, src_in[3:0]} - {4'h0, cin};
    a         = 8'h00;
    case (op_in)
      OP_SUB, OP_SUBTRACT_EXTENDED, OP_SBC, OP_SBCX: begin
        res_out    = diff[7:0];
        wb_out     = 1'b1;
        cond_out.c = diff[8];
        cond_out.z = (diff[7:0] == 8'h00);
        cond_out.s = diff[7];
        cond_out.v = (dst_in[7] ^ src_in[7]) & (dst_in[7] ^ diff[7]);
        cond_out.d = 1'b1;
        cond_out.h = hdiff[4];
      end
      OP_TM, OP_TMX, OP_TCM, OP_INVERTED_MASK_TEST_EXTENDED: begin
        a = ((op_in == OP_TCM) || (op_in == OP_INVERTED_MASK_TEST_EXTENDED)) ? (~dst_in & src_in) : (dst_in & src_in);
        cond_out.z = (a == 8'h00);
        cond_out.s = a[7];
        cond_out.v = 1'b0;
      end
      OP_OR, OP_XOR: begin
        res_out    = (op_in == OP_OR) ? (dst_in | src_in) : (dst_in ^ src_in);
        wb_out     = 1'b1;
        cond_out.z = (res_out == 8'h00);
        cond_out.s = res_out[7];
        cond_out.v = 1'b0;
      end
      OP_SWAP: begin
        res_out    = {dst_in[3:0], dst_in[7:4]};
        wb_out     = 1'b1;
        cond_out.z = (res_out == 8'h00);
        cond_out.s = res_out[7];
      end
      OP_RCF: begin
        cond_out.c = 1'b0;
      end
      OP_SCF: begin
        cond_out.c = 1'b1;
      end
      OP_PREFIX: begin
        if ((op2_in == OP2_SRL_R) || (op2_in == OP2_SRL_IR)) begin
          res_out    = {1'b0, dst_in[7:1]};
          wb_out     = 1'b1;
          cond_out.c = dst_in[0];
          cond_out.z = (dst_in[7:1] == 7'h00);
          cond_out.s = 1'b0;
          cond_out.v = dst_in[0];
        end else begin
          legal_out = 1'b0;
        end
      end
      default: begin
        legal_out = 1'b0;
      end
    endcase
  end

endmodule

// File: src/csf_core.sv
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
// How it works
// - status register keeps the condition results of the latest data operation
// - six condition bits: carry, zero, sign, overflow, half-carry, decimal-adjust
// - jump conditions test only carry, overflow, zero and sign
// - half-carry and decimal-adjust never select a jump condition
// - user flags change only by explicit flag write or interrupt return reload, never by arithmetic
// - user flags are not jump conditions
// - user flags have no reset; reset leaves them as they were
// - interrupt, software trap and illegal opcode push the whole status register
// - interrupt return reloads the status register from the stack
// - trap: sp-2, push pc, sp-1, push flags, pc from vector, flags kept
// - logical shift right: zero into bit 7, bit 0 to carry, sign cleared
// - result flags computed, unmarked flags kept, constant flags forced
module csf_core import csf_pkg::*; (
  input  wire logic         clk_in,
  input  wire logic         arst_n_in,
  input  wire csf_apb_req_t apb_req_in,
  output csf_apb_rsp_t      apb_rsp_out,
  input  wire logic         irq_req_in,
  output csf_flags_t        flags_out,
  output logic              cond_taken_out,
  output logic              busy_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    csf_state_t  state;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [15:0] vec;
    logic [15:0] cmd;
    logic [7:0]  dst;
    logic [7:0]  src;
    logic [7:0]  result;
    logic        wb;
    csf_cond_t   cond;
    logic [3:0]  cc;
    logic        irq_pend;
    logic [1:0]  cause;
    logic [31:0] rdata;
    logic        slverr;
  } csf_core_st_t;

  localparam csf_core_st_t ST_RST = '{
    state: ST_IDLE, sp: SP_RST, pc: PC_RST, vec: VEC_RST, cmd: 16'h0000,
    dst: 8'h00, src: 8'h00, result: 8'h00, wb: 1'b0, cond: '0, cc: 4'h0,
    irq_pend: 1'b0, cause: CAUSE_NONE, rdata: 32'h0000_0000, slverr: 1'b0
  };

  csf_core_st_t st_q;
  csf_core_st_t st_d;
  logic [1:0]   uf_q;
  logic [1:0]   uf_d;

  // ----------------------------------------------------------------
  // condition code evaluation
  // ----------------------------------------------------------------
  function automatic logic cc_eval(input logic [3:0] cc, input csf_cond_t f);
    logic t;
    t = 1'b0;
    case (cc[2:0])
      3'h0:    t = 1'b0;
      3'h1:    t = f.s ^ f.v;
      3'h2:    t = f.z | (f.s ^ f.v);
      3'h3:    t = f.c | f.z;
      3'h4:    t = f.v;
      3'h5:    t = f.s;
      3'h6:    t = f.z;
      default: t = f.c;
    endcase
    return cc[3] ^ t;              // only c, v, z, s reach here
  endfunction

  function automatic logic is_addr(input logic [APB_AW-1:0] a);
    return (a == ADDR_CMD) || (a == ADDR_OPND) || (a == ADDR_RESULT) || (a == ADDR_FLAGS) ||
           (a == ADDR_SP) || (a == ADDR_PC) || (a == ADDR_VEC) || (a == ADDR_COND);
  endfunction

  // ----------------------------------------------------------------
  // datapath and stack
  // ----------------------------------------------------------------
  logic [7:0]  alu_res;
  logic        alu_wb;
  csf_cond_t   alu_cond;
  logic        alu_legal;
  logic        stk_we;
  logic [15:0] stk_waddr;
  logic [7:0]  stk_wdata;
  logic [15:0] sp_p1;
  logic [7:0]  stk_rd_a;
  logic [7:0]  stk_rd_b;
  csf_flags_t  full_flags;
  logic        cond_taken;

  assign full_flags = '{cond: st_q.cond, uf: uf_q};
  assign sp_p1      = st_q.sp + 16'h0001;
  assign cond_taken = cc_eval(st_q.cc, st_q.cond);

  csf_alu u_alu (
    .op_in     (apb_req_in.pwdata[7:0]),
    .op2_in    (apb_req_in.pwdata[CMD_OP2_LSB +: 8]),
    .dst_in    (st_q.dst),
    .src_in    (st_q.src),
    .cond_in   (st_q.cond),
    .res_out   (alu_res),
    .wb_out    (alu_wb),
    .cond_out  (alu_cond),
    .legal_out (alu_legal)
  );

  csf_stack #(.AW(STK_AW)) u_stack (
    .clk_in      (clk_in),
    .we_in       (stk_we),
    .waddr_in    (stk_waddr[STK_AW-1:0]),
    .wdata_in    (stk_wdata),
    .raddr_a_in  (st_q.sp[STK_AW-1:0]),
    .raddr_b_in  (sp_p1[STK_AW-1:0]),
    .rdata_a_out (stk_rd_a),
    .rdata_b_out (stk_rd_b)
  );

  // stack write port follows the trap sequence
  always_comb begin
    stk_we    = 1'b0;
    stk_waddr = st_q.sp;
    stk_wdata = 8'h00;
    case (st_q.state)
      ST_T_PCH: begin
        stk_we    = 1'b1;
        stk_wdata = st_q.pc[15:8];
      end
      ST_T_PCL: begin
        stk_we    = 1'b1;
        stk_waddr = sp_p1;
        stk_wdata = st_q.pc[7:0];
      end
      ST_T_FLG: begin
        stk_we    = 1'b1;
        stk_waddr = st_q.sp - 16'h0001;
        stk_wdata = full_flags;
      end
      default: begin
        stk_we = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup;
  logic wr;
  logic idle;
  logic cmd_go;
  logic [7:0] cmd_op;

  assign setup  = apb_req_in.psel & ~apb_req_in.penable;
  assign wr     = apb_req_in.psel & apb_req_in.penable & apb_req_in.pwrite;
  assign idle   = (st_q.state == ST_IDLE);
  assign cmd_op = apb_req_in.pwdata[7:0];
  assign cmd_go = wr & (apb_req_in.paddr == ADDR_CMD) & idle & ~st_q.irq_pend;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    uf_d = uf_q;
    if (irq_req_in) begin
      st_d.irq_pend = 1'b1;
    end
    if (setup) begin
      st_d.slverr = ~is_addr(apb_req_in.paddr);
      case (apb_req_in.paddr)
        ADDR_CMD:    st_d.rdata = {16'h0000, st_q.cmd};
        ADDR_OPND:   st_d.rdata = {16'h0000, st_q.src, st_q.dst};
        ADDR_RESULT: st_d.rdata = {14'h0000, st_q.irq_pend, ~idle, 5'h00, st_q.cause, st_q.wb, st_q.result};
        ADDR_FLAGS:  st_d.rdata = {24'h000000, full_flags};
        ADDR_SP:     st_d.rdata = {16'h0000, st_q.sp};
        ADDR_PC:     st_d.rdata = {16'h0000, st_q.pc};
        ADDR_VEC:    st_d.rdata = {16'h0000, st_q.vec};
        ADDR_COND:   st_d.rdata = {24'h000000, st_q.cc, 3'h0, cond_taken};
        default:     st_d.rdata = 32'h0000_0000;
      endcase
    end
    if (wr && idle) begin
      case (apb_req_in.paddr)
        ADDR_OPND: begin
          st_d.dst = apb_req_in.pwdata[7:0];
          st_d.src = apb_req_in.pwdata[OPND_SRC_LSB +: 8];
        end
        ADDR_FLAGS: begin
          st_d.cond = csf_cond_t'(apb_req_in.pwdata[7:2]);
          uf_d      = apb_req_in.pwdata[1:0];
        end
        ADDR_SP:   st_d.sp  = apb_req_in.pwdata[15:0];
        ADDR_PC:   st_d.pc  = apb_req_in.pwdata[15:0];
        ADDR_VEC:  st_d.vec = apb_req_in.pwdata[15:0];
        ADDR_COND: st_d.cc  = apb_req_in.pwdata[3:0];
        default:   st_d.cc  = st_d.cc;
      endcase
    end
    if (wr && (apb_req_in.paddr == ADDR_COND) && !idle) begin
      st_d.cc = apb_req_in.pwdata[3:0];
    end
    case (st_q.state)
      ST_IDLE: begin
        if (st_q.irq_pend) begin
          st_d.irq_pend = irq_req_in;                                // new request wins
          st_d.cause    = CAUSE_IRQ;
          st_d.state    = ST_T_SPDEC2;
        end else if (cmd_go) begin
          st_d.cmd = apb_req_in.pwdata[15:0];
          if (cmd_op == OP_TRAP) begin
            st_d.cause = CAUSE_SW;
            st_d.state = ST_T_SPDEC2;
          end else if (cmd_op == OP_INTERRUPT_RETURN_OP) begin
            st_d.state = ST_R_FLG;
          end else if (alu_legal) begin
            st_d.cond = alu_cond;
            st_d.wb   = alu_wb;
            if (alu_wb) begin
              st_d.result = alu_res;
            end
          end else begin
            st_d.cause = CAUSE_ILL;
            st_d.state = ST_T_SPDEC2;
          end
        end
      end
      ST_T_SPDEC2: begin
        st_d.sp    = st_q.sp - 16'h0002;
        st_d.state = ST_T_PCH;
      end
      ST_T_PCH: st_d.state = ST_T_PCL;
      ST_T_PCL: st_d.state = ST_T_FLG;
      ST_T_FLG: begin
        st_d.sp    = st_q.sp - 16'h0001;
        st_d.state = ST_T_VEC;
      end
      ST_T_VEC: begin
        st_d.pc    = st_q.vec;
        st_d.state = ST_IDLE;
      end
      ST_R_FLG: begin
        st_d.cond  = csf_cond_t'(stk_rd_a[7:2]);
        uf_d       = stk_rd_a[1:0];
        st_d.sp    = sp_p1;
        st_d.state = ST_R_PC;
      end
      ST_R_PC: begin
        st_d.pc    = {stk_rd_a, stk_rd_b};
        st_d.sp    = st_q.sp + 16'h0002;
        st_d.state = ST_IDLE;
      end
      default: st_d.state = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // user flags carry no reset
  always_ff @(posedge clk_in) begin
    uf_q <= uf_d;
  end

  assign apb_rsp_out.pready  = 1'b1;
  assign apb_rsp_out.prdata  = st_q.rdata;
  assign apb_rsp_out.pslverr = st_q.slverr;
  assign flags_out           = full_flags;
  assign cond_taken_out      = cond_taken;
  assign busy_out            = ~idle;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic srl_go;
  logic sub_go;
  logic tm_go;
  logic ill_go;
  logic flg_wr;

  assign srl_go = cmd_go & (cmd_op == OP_PREFIX) & alu_legal;
  assign sub_go = cmd_go & ((cmd_op == OP_SUB) | (cmd_op == OP_SUBTRACT_EXTENDED) | (cmd_op == OP_SBC) | (cmd_op == OP_SBCX));
  assign tm_go  = cmd_go & ((cmd_op == OP_TM) | (cmd_op == OP_TMX) | (cmd_op == OP_TCM) | (cmd_op == OP_INVERTED_MASK_TEST_EXTENDED));
  assign ill_go = cmd_go & (cmd_op != OP_TRAP) & (cmd_op != OP_INTERRUPT_RETURN_OP) & ~alu_legal;
  assign flg_wr = wr & idle & (apb_req_in.paddr == ADDR_FLAGS);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  property p_srl;
    srl_go |=> (st_q.result == {1'b0, $past(st_q.dst[7:1])}) && (st_q.cond.c == $past(st_q.dst[0])) && !st_q.cond.s;
  endproperty
  a_srl: assert property (p_srl) else $error("shift right result or flags wrong");

  property p_sub_d;
    sub_go |=> st_q.cond.d && st_q.wb;
  endproperty
  a_sub_d: assert property (p_sub_d) else $error("subtract did not set decimal-adjust");

  property p_tm;
    tm_go |=> (st_q.result == $past(st_q.result)) && (st_q.cond.c == $past(st_q.cond.c)) && !st_q.cond.v;
  endproperty
  a_tm: assert property (p_tm) else $error("mask test wrote result or touched carry");

  property p_uf_stable;
    !(flg_wr || (st_q.state == ST_R_FLG)) |=> $stable(uf_q);
  endproperty
  a_uf_stable: assert property (p_uf_stable) else $error("user flags changed without explicit write");

  property p_trap_seq;
    (st_q.state == ST_T_SPDEC2) |-> ##5 (idle && (st_q.pc == $past(st_q.vec, 1))
      && (st_q.sp == 16'($past(st_q.sp, 5) - 16'h0003)));
  endproperty
  a_trap_seq: assert property (p_trap_seq) else $error("trap sequence timing or pointers wrong");

  property p_trap_flags;
    (st_q.state == ST_T_SPDEC2) |-> ##5 (st_q.cond == $past(st_q.cond, 5));
  endproperty
  a_trap_flags: assert property (p_trap_flags) else $error("trap altered flags");

  property p_push_flags;
    (st_q.state == ST_T_FLG) |=> (st_q.state == ST_T_VEC) && (stk_rd_a == $past(full_flags));
  endproperty
  a_push_flags: assert property (p_push_flags) else $error("flags not pushed");

  property p_interrupt_return_op;
    (st_q.state == ST_R_FLG) |=> (full_flags == $past(stk_rd_a));
  endproperty
  a_interrupt_return_op: assert property (p_interrupt_return_op) else $error("interrupt return did not reload flags");

  property p_cc_indep;
    ($stable(st_q.cc) && $stable({st_q.cond.c, st_q.cond.z, st_q.cond.s, st_q.cond.v})) |-> $stable(cond_taken);
  endproperty
  a_cc_indep: assert property (p_cc_indep) else $error("jump condition depends on other bits");

  property p_ill;
    ill_go |=> (st_q.state == ST_T_SPDEC2) && (st_q.cause == CAUSE_ILL);
  endproperty
  a_ill: assert property (p_ill) else $error("illegal opcode did not trap");

  property p_alu_flags;
    (cmd_go && alu_legal && (cmd_op != OP_TRAP) && (cmd_op != OP_INTERRUPT_RETURN_OP)) |=> st_q.cond == $past(alu_cond);
  endproperty
  a_alu_flags: assert property (p_alu_flags) else $error("flags not taken from latest operation");

  c_sw_trap: cover property ((st_q.state == ST_T_VEC) && (st_q.cause == CAUSE_SW));
  c_irq:     cover property ((st_q.state == ST_T_SPDEC2) && (st_q.cause == CAUSE_IRQ));
  c_interrupt_return_op:    cover property ((st_q.state == ST_R_PC) ##1 idle);
  c_srl:     cover property (srl_go);

endmodule

// File: tb/test_cpu_status_flags_and_ops.sv
`timescale 1ns/1ps
module test_cpu_status_flags_and_ops import csf_pkg::*; ;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic         clk_in     = 1'b0;
  logic         arst_n_in  = 1'b0;
  logic         irq_req_in = 1'b0;
  csf_apb_req_t req        = '0;
  csf_apb_rsp_t rsp;
  csf_flags_t   flags;
  logic         taken;
  logic         busy;
  logic [31:0]  rd;
  logic         err;
  int           miscompares = 0;
  int           checked     = 0;
  logic [7:0]   fl_tab [2]  = '{8'hAC, 8'h0F};
  logic [7:0]   tk_tab [2]  = '{8'hAE, 8'h00};

  always #20 clk_in = ~clk_in;

  csf_core i_dut (
    .clk_in         (clk_in),
    .arst_n_in      (arst_n_in),
    .apb_req_in     (req),
    .apb_rsp_out    (rsp),
    .irq_req_in     (irq_req_in),
    .flags_out      (flags),
    .cond_taken_out (taken),
    .busy_out       (busy)
  );

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_in);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(name, exp, rd & msk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge clk_in);
    while (busy !== 1'b0 && n < 40) begin
      @(posedge clk_in);
      n++;
    end
    chk("busy_out", 32'h0000_0000, {31'h0, busy});
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    miscompares++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    chk("flags_cond_reset", 32'h0000_0000, {26'h0, flags.cond});
    wr(ADDR_FLAGS, 32'h0000_0002);
    wr(ADDR_OPND, 32'h0000_2010);
    wr(ADDR_CMD, {24'h0, OP_SUB});
    rdc("sub_result", ADDR_RESULT, 32'h0000_01FF, 32'h0000_01F0);
    chk("sub_flags", 32'h0000_00AA, {24'h0, flags});
    wr(ADDR_OPND, 32'h0000_F00F);
    wr(ADDR_CMD, {24'h0, OP_TM});
    rdc("tm_result", ADDR_RESULT, 32'h0000_01FF, 32'h0000_00F0);
    chk("tm_flags", 32'h0000_00CA, {24'h0, flags});
    wr(ADDR_OPND, 32'h0000_0081);
    wr(ADDR_CMD, {16'h0, OP2_SRL_R, OP_PREFIX});
    rdc("srl_result", ADDR_RESULT, 32'h0000_01FF, 32'h0000_0140);
    chk("srl_flags", 32'h0000_009A, {24'h0, flags});
    wr(ADDR_OPND, 32'h0000_0110);
    wr(ADDR_CMD, {24'h0, OP_SBC});
    rdc("sbc_result", ADDR_RESULT, 32'h0000_01FF, 32'h0000_010E);
    chk("sbc_flags", 32'h0000_000E, {24'h0, flags});
    wr(ADDR_CMD, {24'h0, OP_SCF});
    rdc("scf_flags", ADDR_FLAGS, 32'h0000_00FF, 32'h0000_008E);
    wr(ADDR_OPND, 32'h0000_FF0F);
    wr(ADDR_CMD, {24'h0, OP_XOR});
    rdc("xor_result", ADDR_RESULT, 32'h0000_01FF, 32'h0000_01F0);
    chk("xor_flags", 32'h0000_00AE, {24'h0, flags});
    wr(ADDR_CMD, {24'h0, OP_RCF});
    rdc("rcf_flags", ADDR_FLAGS, 32'h0000_00FF, 32'h0000_002E);
    wr(ADDR_OPND, 32'h0000_0001);
    wr(ADDR_CMD, {24'h0, OP_SWAP});
    rdc("swap_result", ADDR_RESULT, 32'h0000_01FF, 32'h0000_0110);
    chk("swap_flags", 32'h0000_000E, {24'h0, flags & 8'h6F});
    $display("alu flag tests done");
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_FLAGS, {24'h0, fl_tab[i]});
      for (int c = 0; c < 8; c++) begin
        wr(ADDR_COND, 32'(c));
        @(posedge clk_in);
        chk("cond_taken_out", {31'h0, tk_tab[i][c]}, {31'h0, taken});
      end
    end
    wr(ADDR_COND, 32'h0000_000F);
    @(posedge clk_in);
    chk("cond_inverted", 32'h0000_0001, {31'h0, taken});
    $display("condition tests done");
    wr(ADDR_FLAGS, 32'h0000_00AC);
    wr(ADDR_SP, 32'h0000_0008);
    wr(ADDR_PC, 32'h0000_1234);
    wr(ADDR_VEC, 32'h0000_0456);
    wr(ADDR_CMD, {24'h0, OP_TRAP});
    wait_idle();
    rdc("trap_sp", ADDR_SP, 32'h0000_FFFF, 32'h0000_0005);
    rdc("trap_pc", ADDR_PC, 32'h0000_FFFF, 32'h0000_0456);
    rdc("trap_cause", ADDR_RESULT, 32'h0000_0600, 32'(CAUSE_SW) << RES_CAUSE_LSB);
    chk("trap_flags", 32'h0000_00AC, {24'h0, flags});
    wr(ADDR_FLAGS, 32'h0000_000F);
    wr(ADDR_CMD, {24'h0, OP_INTERRUPT_RETURN_OP});
    wait_idle();
    chk("interrupt_return_op_flags", 32'h0000_00AC, {24'h0, flags});
    rdc("interrupt_return_op_sp", ADDR_SP, 32'h0000_FFFF, 32'h0000_0008);
    rdc("interrupt_return_op_pc", ADDR_PC, 32'h0000_FFFF, 32'h0000_1234);
    wr(ADDR_CMD, 32'h0000_0000);
    wait_idle();
    rdc("ill_cause", ADDR_RESULT, 32'h0000_0600, 32'(CAUSE_ILL) << RES_CAUSE_LSB);
    wr(ADDR_FLAGS, 32'h0000_000F);
    wr(ADDR_CMD, {24'h0, OP_INTERRUPT_RETURN_OP});
    wait_idle();
    chk("ill_interrupt_return_op_flags", 32'h0000_00AC, {24'h0, flags});
    $display("trap tests done");
    @(posedge clk_in);
    irq_req_in <= 1'b1;
    @(posedge clk_in);
    irq_req_in <= 1'b0;
    @(posedge clk_in);
    wait_idle();
    rdc("irq_cause", ADDR_RESULT, 32'h0000_0600, 32'(CAUSE_IRQ) << RES_CAUSE_LSB);
    rdc("irq_sp", ADDR_SP, 32'h0000_FFFF, 32'h0000_0005);
    wr(ADDR_FLAGS, 32'h0000_000F);
    wr(ADDR_CMD, {24'h0, OP_INTERRUPT_RETURN_OP});
    wait_idle();
    chk("irq_interrupt_return_op_flags", 32'h0000_00AC, {24'h0, flags});
    xfer(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped_err", 32'h0000_0001, {31'h0, err});
    chk("unmapped_data", 32'h0000_0000, rd);
    $display("interrupt and bus tests done");
    wr(ADDR_FLAGS, 32'h0000_0001);
    @(posedge clk_in);
    arst_n_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    chk("flags_after_reset", 32'h0000_0001, {24'h0, flags});
    $display("reset test done");
    complete_run();
  end
endmodule
